/* File: rtl/dhasp_defines.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef DHASP_DEFINES_SVH
`define DHASP_DEFINES_SVH

// Host I/O port addresses.
`define DHASP_PORT_CFG_INDEX   16'h0028
`define DHASP_PORT_CFG_DATA    16'h0024
`define DHASP_PORT_SYS_B       16'h0061
`define DHASP_PORT_RTC_NMI     16'h0070
`define DHASP_PORT_SYSCTL      16'h0092

// Configuration index numbers.
`define DHASP_IDX_CONFIG       8'h02
`define DHASP_IDX_HOLE_EN      8'h08
`define DHASP_IDX_IO_START     8'h10
`define DHASP_IDX_IO_END       8'h11
`define DHASP_IDX_MEM_START_LO 8'h19
`define DHASP_IDX_MEM_START_HI 8'h1a
`define DHASP_IDX_MEM_END_LO   8'h1c
`define DHASP_IDX_MEM_END_HI   8'h1d

// Field positions.
`define DHASP_CFG_DEC16_BIT    1
`define DHASP_CFG_SYSCTL_BIT   2
`define DHASP_CFG_PAR_OVR_BIT  5
`define DHASP_HOLE_MEM_BIT     1
`define DHASP_HOLE_IO_BIT      3
`define DHASP_PB_T2_GATE_BIT   0
`define DHASP_PB_SPK_BIT       1
`define DHASP_PB_PAR_DIS_BIT   2
`define DHASP_PB_CHK_DIS_BIT   3
`define DHASP_NMI_MASK_BIT     7
`define DHASP_SC_FRST_BIT      0
`define DHASP_SC_A20_BIT       1

// Reset values.
`define DHASP_CFG_RESET        8'h00
`define DHASP_IDX_RESET        8'h00
`define DHASP_HOLE_EN_RESET    8'h00
`define DHASP_HOLE_REG_RESET   8'h00
`define DHASP_PB_RESET         4'h0
`define DHASP_SYSCTL_RESET     2'h0
`define DHASP_RTC_IDX_RESET    7'h00
`define DHASP_PIN_IDLE         5'h13

// Fast CPU reset timing.
`define DHASP_CLK_NS           10
`define DHASP_FRST_DELAY_NS    6720
`define DHASP_FRST_PULSE_NS    125
`define DHASP_FRST_DELAY_CYC   ((`DHASP_FRST_DELAY_NS + `DHASP_CLK_NS - 1) / `DHASP_CLK_NS)
`define DHASP_FRST_PULSE_CYC   ((`DHASP_FRST_PULSE_NS + `DHASP_CLK_NS - 1) / `DHASP_CLK_NS)

`endif

/* File: rtl/dhasp_pkg.sv */
// Types used by the fast CPU reset logic of the system control port.
package dhasp_pkg;

  // Fast CPU reset sequencer states.
  typedef enum logic [1:0] {
    DHASP_FRST_IDLE,
    DHASP_FRST_WAIT,
    DHASP_FRST_PULSE
  } dhasp_frst_state_t;

endpackage

/* File: rtl/dhasp_system_ports.sv */
// Decode holes, AT system port B, NMI mask, RTC index and system control port.
`timescale 1ns/1ps
`default_nettype none
`include "dhasp_defines.svh"

// Operation
// - Enabled hole hit means controller neither starts nor ends the cycle.
// - I/O hole granularity is 16 bytes, one unit minimum.
// - I/O hole bounds compare against I/O address bits 11 to 4.
// - Hole enable bit 3 switches the I/O hole on.
// - Hole enable bit 1 switches the memory hole on; others reserved.
// - Memory hole granularity is 16K, no upper size limit; the exclusive 14-bit end bound cannot reach the top 16K unit.
// - Memory bounds split: low byte bits 21-14, high bits 5:0 bits 27-22.
// - Port B bit 0 gates timer 2, bit 1 gates speaker; reset 0.
// - Port B bit 2 ORed with parity override disables parity sampling.
// - Port B bit 3 disables channel-check sampling; default enabled.
// - Port B bit 4 toggles per refresh, bit 5 shows timer 2 output.
// - Low channel check while enabled sets bit 6 until disabled or reset.
// - Parity input sampled each edge; low while enabled sets bit 7.
// - NMI is OR of both flags unless masked by port 70 bit 7.
// - Port 70 bits 6:0 drive the external RTC index pointer.
// - Port 92 answers only while config 02 bit 2 set; resets to 00.
// - Port 92 bit 1 drives the A20 clamp directly until rewritten.
// - Bit 0 rising makes one CPU reset pulse 6.72 us after the write.
// - Port 92 bit 0 keeps its set value after the fast reset.
// - Keyboard A20 clamp and reset requests combine with port 92 functions.
// - Config 02 bit 5 stops flagged parity errors reaching NMI.
module dhasp_system_ports (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        io_write,
  input  wire logic        io_read,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_valid,
  input  wire logic        cyc_valid,
  input  wire logic        cyc_is_io,
  input  wire logic [27:0] cyc_addr,
  output logic             hole_hit,
  output logic             cyc_claim,
  input  wire logic        refresh_cycle,
  input  wire logic        parity_b,
  input  wire logic        channel_check_input_b,
  input  wire logic        timer2_output,
  input  wire logic        keyboard_cpu_reset,
  input  wire logic        keyboard_a20_clamp_b,
  output logic             timer2_gate,
  output logic             speaker_enable,
  output logic             nmi,
  output logic      [6:0]  rtc_index,
  output logic             a20_clamp_output_b,
  output logic             cpu_reset_output
);

  localparam logic [9:0] FRST_DELAY = 10'(`DHASP_FRST_DELAY_CYC);
  localparam logic [9:0] FRST_PULSE = 10'(`DHASP_FRST_PULSE_CYC);

  // Port address compare; 10-bit mode ignores the upper six address lines.
  function automatic logic port_hit(input logic [15:0] addr,
                                    input logic [15:0] port,
                                    input logic        dec16);
    port_hit = dec16 ? (addr == port) : (addr[9:0] == port[9:0]);
  endfunction

  // Half-open range test shared by both holes.
  function automatic logic in_range(input logic [13:0] value,
                                    input logic [13:0] lo,
                                    input logic [13:0] hi);
    in_range = (value >= lo) && (value < hi);
  endfunction

  logic [1:0]  rst_sync;
  logic        rst_int_b;
  logic [4:0]  pin_s1;
  logic [4:0]  pin_s2;
  logic [4:0]  pin_s3;
  logic [4:0]  pin_filt;
  logic [7:0]  cfg_index;
  logic [7:0]  cfg_main;
  logic [7:0]  hole_en;
  logic [7:0]  io_start;
  logic [7:0]  io_end;
  logic [7:0]  mem_start_lo;
  logic [7:0]  mem_start_hi;
  logic [7:0]  mem_end_lo;
  logic [7:0]  mem_end_hi;
  logic [3:0]  port_b;
  logic        refresh_toggle;
  logic        channel_check_flag;
  logic        memory_parity_flag;
  logic        nmi_mask;
  logic [1:0]  sysctl;
  logic        frst_pulse;
  logic [9:0]  frst_count;
  dhasp_pkg::dhasp_frst_state_t frst_state;

  logic        dec16;
  logic        sysctl_port_enable;
  logic        hit_index;
  logic        hit_data;
  logic        hit_port_b;
  logic        hit_rtc;
  logic        hit_sysctl;
  logic        parity_disable;
  logic        io_hole_match;
  logic        mem_hole_match;
  logic        fast_cpu_reset;
  logic [7:0]  cfg_rdata;
  logic [7:0]  next_rdata;

  // Release reset through two flops so every flop leaves reset together.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync[1];

  // Pins pass three flops; a level is accepted once stages two and three
  // agree, so a single metastable sample never reaches the flags.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      pin_s1   <= `DHASP_PIN_IDLE;
      pin_s2   <= `DHASP_PIN_IDLE;
      pin_s3   <= `DHASP_PIN_IDLE;
      pin_filt <= `DHASP_PIN_IDLE;
    end else begin
      pin_s1 <= {keyboard_a20_clamp_b, keyboard_cpu_reset, timer2_output,
                 channel_check_input_b, parity_b};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 5; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_filt[i] <= pin_s3[i];
        end
      end
    end
  end

  // Address decode of the host ports.
  assign dec16              = cfg_main[`DHASP_CFG_DEC16_BIT];
  assign sysctl_port_enable = cfg_main[`DHASP_CFG_SYSCTL_BIT];
  assign hit_index  = port_hit(io_addr, `DHASP_PORT_CFG_INDEX, dec16);
  assign hit_data   = port_hit(io_addr, `DHASP_PORT_CFG_DATA, dec16);
  assign hit_port_b = port_hit(io_addr, `DHASP_PORT_SYS_B, dec16);
  assign hit_rtc    = port_hit(io_addr, `DHASP_PORT_RTC_NMI, dec16);
  assign hit_sysctl = port_hit(io_addr, `DHASP_PORT_SYSCTL, dec16) &&
                      sysctl_port_enable;

  // The index pointer holds until the next write to the index port.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      cfg_index <= `DHASP_IDX_RESET;
    end else if (io_write && hit_index) begin
      cfg_index <= io_wdata;
    end
  end

  // Indexed configuration registers written through the data port.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      cfg_main     <= `DHASP_CFG_RESET;
      hole_en      <= `DHASP_HOLE_EN_RESET;
      io_start     <= `DHASP_HOLE_REG_RESET;
      io_end       <= `DHASP_HOLE_REG_RESET;
      mem_start_lo <= `DHASP_HOLE_REG_RESET;
      mem_start_hi <= `DHASP_HOLE_REG_RESET;
      mem_end_lo   <= `DHASP_HOLE_REG_RESET;
      mem_end_hi   <= `DHASP_HOLE_REG_RESET;
    end else if (io_write && hit_data) begin
      case (cfg_index)
        `DHASP_IDX_CONFIG:       cfg_main     <= io_wdata;
        `DHASP_IDX_HOLE_EN:      hole_en      <= io_wdata;
        `DHASP_IDX_IO_START:     io_start     <= io_wdata;
        `DHASP_IDX_IO_END:       io_end       <= io_wdata;
        `DHASP_IDX_MEM_START_LO: mem_start_lo <= io_wdata;
        `DHASP_IDX_MEM_START_HI: mem_start_hi <= io_wdata;
        `DHASP_IDX_MEM_END_LO:   mem_end_lo   <= io_wdata;
        `DHASP_IDX_MEM_END_HI:   mem_end_hi   <= io_wdata;
        default: begin
        end
      endcase
    end
  end

  // Hole compare; the end bound is exclusive, so software writes top + 1.
  // Only address bits 11:4 take part for I/O, giving 16-byte units.
  assign io_hole_match  = hole_en[`DHASP_HOLE_IO_BIT] &&
                          in_range({6'h00, cyc_addr[11:4]},
                                   {6'h00, io_start},
                                   {6'h00, io_end});
  // Memory units are 16K; the exclusive 14-bit end bound stops one unit short of the top of the space.
  assign mem_hole_match = hole_en[`DHASP_HOLE_MEM_BIT] &&
                          in_range(cyc_addr[27:14],
                                   {mem_start_hi[5:0], mem_start_lo},
                                   {mem_end_hi[5:0], mem_end_lo});

  // One cycle after each host cycle, say whether the controller stays off
  // the bus or claims the cycle as the default device.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      hole_hit  <= 1'b0;
      cyc_claim <= 1'b0;
    end else begin
      hole_hit  <= cyc_valid &&
                   (cyc_is_io ? io_hole_match : mem_hole_match);
      cyc_claim <= cyc_valid &&
                   !(cyc_is_io ? io_hole_match : mem_hole_match);
    end
  end

  // Writable half of port B; the upper bits are status only.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      port_b <= `DHASP_PB_RESET;
    end else if (io_write && hit_port_b) begin
      port_b <= io_wdata[3:0];
    end
  end

  // Refresh detect flips once per refresh cycle.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      refresh_toggle <= 1'b0;
    end else if (refresh_cycle) begin
      refresh_toggle <= !refresh_toggle;
    end
  end

  // Parity override and port B disable act as one disable.
  assign parity_disable = port_b[`DHASP_PB_PAR_DIS_BIT] ||
                          cfg_main[`DHASP_CFG_PAR_OVR_BIT];

  // Error flags stay set while sampling is enabled. Clearing only happens
  // while the disable is high, and then no set can occur, so an error is
  // never lost against a clear.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      channel_check_flag <= 1'b0;
    end else if (port_b[`DHASP_PB_CHK_DIS_BIT]) begin
      channel_check_flag <= 1'b0;
    end else if (!pin_filt[1]) begin
      channel_check_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      memory_parity_flag <= 1'b0;
    end else if (parity_disable) begin
      memory_parity_flag <= 1'b0;
    end else if (!pin_filt[0]) begin
      memory_parity_flag <= 1'b1;
    end
  end

  // NMI mask and RTC index; power-up leaves NMI masked.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      nmi_mask  <= 1'b1;
      rtc_index <= `DHASP_RTC_IDX_RESET;
    end else if (io_write && hit_rtc) begin
      nmi_mask  <= io_wdata[`DHASP_NMI_MASK_BIT];
      rtc_index <= io_wdata[6:0];
    end
  end

  // System control port; bit 0 is kept after the reset it causes.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      sysctl <= `DHASP_SYSCTL_RESET;
    end else if (io_write && hit_sysctl) begin
      sysctl <= io_wdata[1:0];
    end
  end

  // A new pulse needs bit 0 to go from 0 to 1 in a single write.
  assign fast_cpu_reset = io_write && hit_sysctl &&
                          io_wdata[`DHASP_SC_FRST_BIT] &&
                          !sysctl[`DHASP_SC_FRST_BIT];

  // Fast reset sequencer: wait, then one fixed-width pulse. A fresh
  // trigger restarts the wait, which keeps only one pulse per trigger.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      frst_state <= dhasp_pkg::DHASP_FRST_IDLE;
      frst_count <= 10'h000;
      frst_pulse <= 1'b0;
    end else if (fast_cpu_reset) begin
      frst_state <= dhasp_pkg::DHASP_FRST_WAIT;
      frst_count <= 10'h001;
      frst_pulse <= 1'b0;
    end else begin
      case (frst_state)
        dhasp_pkg::DHASP_FRST_IDLE: begin
          frst_pulse <= 1'b0;
        end
        dhasp_pkg::DHASP_FRST_WAIT: begin
          if (frst_count == FRST_DELAY) begin
            frst_state <= dhasp_pkg::DHASP_FRST_PULSE;
            frst_count <= 10'h001;
            frst_pulse <= 1'b1;
          end else begin
            frst_count <= frst_count + 10'h001;
          end
        end
        dhasp_pkg::DHASP_FRST_PULSE: begin
          if (frst_count == FRST_PULSE) begin
            frst_state <= dhasp_pkg::DHASP_FRST_IDLE;
            frst_count <= 10'h000;
            frst_pulse <= 1'b0;
          end else begin
            frst_count <= frst_count + 10'h001;
          end
        end
        default: begin
          frst_state <= dhasp_pkg::DHASP_FRST_IDLE;
          frst_count <= 10'h000;
          frst_pulse <= 1'b0;
        end
      endcase
    end
  end

  // Outputs toward the CPU, timer and speaker, all from flops.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      timer2_gate        <= 1'b0;
      speaker_enable     <= 1'b0;
      nmi                <= 1'b0;
      a20_clamp_output_b <= 1'b0;
      cpu_reset_output   <= 1'b0;
    end else begin
      timer2_gate        <= port_b[`DHASP_PB_T2_GATE_BIT];
      speaker_enable     <= port_b[`DHASP_PB_SPK_BIT];
      nmi                <= !nmi_mask &&
                            (channel_check_flag || memory_parity_flag);
      // Either source may clamp A20 low.
      a20_clamp_output_b <= sysctl[`DHASP_SC_A20_BIT] &&
                            pin_filt[4];
      cpu_reset_output   <= frst_pulse || pin_filt[3];
    end
  end

  // Indexed read mux; unused indices read as zero.
  always_comb begin
    case (cfg_index)
      `DHASP_IDX_CONFIG:       cfg_rdata = cfg_main;
      `DHASP_IDX_HOLE_EN:      cfg_rdata = hole_en;
      `DHASP_IDX_IO_START:     cfg_rdata = io_start;
      `DHASP_IDX_IO_END:       cfg_rdata = io_end;
      `DHASP_IDX_MEM_START_LO: cfg_rdata = mem_start_lo;
      `DHASP_IDX_MEM_START_HI: cfg_rdata = mem_start_hi;
      `DHASP_IDX_MEM_END_LO:   cfg_rdata = mem_end_lo;
      `DHASP_IDX_MEM_END_HI:   cfg_rdata = mem_end_hi;
      default:                 cfg_rdata = 8'h00;
    endcase
  end

  // Port read mux; port 70 is write only and reads as zero.
  always_comb begin
    next_rdata = 8'h00;
    if (hit_index) begin
      next_rdata = cfg_index;
    end else if (hit_data) begin
      next_rdata = cfg_rdata;
    end else if (hit_port_b) begin
      next_rdata = {memory_parity_flag, channel_check_flag, pin_filt[2],
                    refresh_toggle, port_b};
    end else if (hit_sysctl) begin
      next_rdata = {6'h00, sysctl};
    end
  end

  // Read data is captured one cycle after the read strobe and held.
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      io_rdata       <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_read;
      if (io_read) begin
        io_rdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/dhasp_pin_model.sv */
// Model of the pins driven by the parity, channel-check, timer and keyboard side.
`timescale 1ns/1ps
`default_nettype none
module dhasp_pin_model (
  input  wire logic clk,
  input  wire logic par_req,
  input  wire logic chk_req,
  input  wire logic t2_req,
  input  wire logic kbrst_req,
  input  wire logic kba20_req,
  input  wire logic ref_req,
  output logic      parity_b,
  output logic      channel_check_input_b,
  output logic      timer2_output,
  output logic      keyboard_cpu_reset,
  output logic      keyboard_a20_clamp_b,
  output logic      refresh_cycle
);
  // Idle levels at time zero, before any request arrives.
  initial begin
    parity_b = 1'b1;
    channel_check_input_b = 1'b1;
    timer2_output = 1'b0;
    keyboard_cpu_reset = 1'b0;
    keyboard_a20_clamp_b = 1'b1;
    refresh_cycle = 1'b0;
  end

  // Pins move on the falling edge, clear of the sampling edge.
  always @(negedge clk) begin
    parity_b <= !par_req;
    channel_check_input_b <= !chk_req;
    timer2_output <= t2_req;
    refresh_cycle <= ref_req;
    keyboard_cpu_reset <= kbrst_req;
    keyboard_a20_clamp_b <= !kba20_req;
  end
endmodule
`default_nettype wire

/* File: bench/dhasp_system_ports_chk.sv */
// Assertion checker bound to the decode hole and system port block.
`timescale 1ns/1ps
`default_nettype none
module dhasp_system_ports_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        io_write,
  input wire logic        io_read,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rdata_valid,
  input wire logic        cyc_valid,
  input wire logic        hole_hit,
  input wire logic        cyc_claim,
  input wire logic        parity_b,
  input wire logic        channel_check_input_b,
  input wire logic        keyboard_cpu_reset,
  input wire logic        keyboard_a20_clamp_b,
  input wire logic        nmi,
  input wire logic [6:0]  rtc_index,
  input wire logic        a20_clamp_output_b,
  input wire logic        cpu_reset_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       wr70;
  logic       unm70;
  logic       wr92;
  logic [3:0] hi_cnt;
  logic [3:0] kb_cnt;
  logic [3:0] err_cnt;
  assign wr70 = io_write && io_addr == 16'h0070;
  assign unm70 = wr70 && !io_wdata[7];
  assign wr92 = io_write && io_addr == 16'h0092;

  // Length of the current reset pulse, saturating.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hi_cnt <= 4'h0;
    else if (!cpu_reset_output) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hf) hi_cnt <= hi_cnt + 4'h1;
  end

  // Keyboard pin effects trail the pins through the filter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) kb_cnt <= 4'h0;
    else if (keyboard_cpu_reset || $changed(keyboard_a20_clamp_b)) kb_cnt <= 4'hf;
    else if (kb_cnt != 4'h0) kb_cnt <= kb_cnt - 4'h1;
  end

  // Window in which an NMI may follow an error pin.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) err_cnt <= 4'h0;
    else if (!parity_b || !channel_check_input_b) err_cnt <= 4'hc;
    else if (err_cnt != 4'h0) err_cnt <= err_cnt - 4'h1;
  end

  sequence s_masked;
    wr70 && io_wdata[7] ##1 !wr70;
  endsequence

  chk_hole_answer: assert property (cyc_valid |=> hole_hit != cyc_claim)
    else $error("hole decode gave no single answer");
  chk_hole_quiet: assert property (!cyc_valid |=> !hole_hit && !cyc_claim)
    else $error("hole decode answered without a cycle");
  chk_rtc_index: assert property (wr70 |=> {1'b0, rtc_index} == ($past(io_wdata) & 8'h7f))
    else $error("rtc index does not follow the write");
  chk_nmi_mask: assert property (s_masked |=> !nmi)
    else $error("nmi active while masked");
  chk_nmi_cause: assert property ($rose(nmi) |-> err_cnt != 4'h0 || $past(unm70, 2) || $past(unm70, 3))
    else $error("nmi rose without a cause");
  chk_pulse_width: assert property ($fell(cpu_reset_output) && kb_cnt == 4'h0 |-> hi_cnt == 4'hd)
    else $error("fast reset pulse has wrong length");
  chk_a20_hold: assert property ($changed(a20_clamp_output_b) |-> kb_cnt != 4'h0 || $past(wr92) || $past(wr92, 2))
    else $error("a20 clamp changed without a write");
  chk_read_answer: assert property (io_read |=> io_rdata_valid)
    else $error("read gave no valid strobe");
  chk_read_hold: assert property (!io_read |=> $stable(io_rdata) && !io_rdata_valid)
    else $error("read data moved without a read");
endmodule

bind dhasp_system_ports dhasp_system_ports_chk dhasp_system_ports_chk_i (.*);
`default_nettype wire

/* File: bench/dhasp_system_ports_test.sv */
// Self-checking testbench for the decode hole and system port block.
`timescale 1ns/1ps
`default_nettype none
module dhasp_system_ports_test;
  logic        clk, rst_b, io_write, io_read, cyc_valid, cyc_is_io;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, v, w;
  logic [27:0] cyc_addr;
  logic [6:0]  rtc_index;
  logic        io_rdata_valid, hole_hit, cyc_claim, timer2_gate, speaker_enable;
  logic        nmi, a20_clamp_output_b, cpu_reset_output, refresh_cycle;
  logic        parity_b, channel_check_input_b, timer2_output;
  logic        keyboard_cpu_reset, keyboard_a20_clamp_b;
  logic        par_req, chk_req, t2_req, kbrst_req, kba20_req, ref_req;
  int          bad_count, n_checks;

  dhasp_system_ports dhasp_system_ports_i (.*);

  dhasp_pin_model dhasp_pin_model_i (.*);

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_write <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(negedge clk);
    io_write <= 1'b0;
  endtask

  // The read strobe is taken on one edge and answered by the next.
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    io_read <= 1'b1;
    io_addr <= a;
    @(negedge clk);
    io_read <= 1'b0;
    d = io_rdata;
    check({15'h0, io_rdata_valid}, 16'h0001);
  endtask

  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    io_wr(16'h0028, {8'h00, i});
    io_wr(16'h0024, d);
  endtask

  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d);
    io_wr(16'h0028, {8'h00, i});
    io_rd(16'h0024, d);
  endtask

  task automatic hole(input logic io, input logic [27:0] a, input logic e);
    @(negedge clk);
    cyc_valid <= 1'b1;
    cyc_is_io <= io;
    cyc_addr <= a;
    @(negedge clk);
    cyc_valid <= 1'b0;
    check({14'h0, hole_hit, cyc_claim}, {14'h0, e, !e});
  endtask

  // Holds an error pin low long enough to pass the input filter.
  task automatic err_pin(input logic par);
    if (par) par_req <= 1'b1;
    else chk_req <= 1'b1;
    ticks(3);
    par_req <= 1'b0;
    chk_req <= 1'b0;
    ticks(10);
  endtask

  // Reads port B and compares both error flags and the NMI line.
  task automatic nmi_rd(input logic [15:0] e);
    io_rd(16'h0061, v);
    check({8'h0, v & 8'hc0, 7'h0, nmi}, e);
  endtask

  task automatic t_regs();
    logic [7:0] idx [8];
    idx = '{8'h02, 8'h08, 8'h10, 8'h11, 8'h19, 8'h1a, 8'h1c, 8'h1d};
    foreach (idx[i]) begin
      cfg_rd(idx[i], v);
      check({8'h0, v}, 16'h0000);
      cfg_wr(idx[i], {2'b00, 3'(i), 3'b101});
      cfg_rd(idx[i], v);
      check({8'h0, v}, {10'h0, 3'(i), 3'b101});
      cfg_wr(idx[i], 8'h00);
    end
    cfg_wr(8'h1f, 8'hff);
    cfg_rd(8'h1f, v);
    check({8'h0, v}, 16'h0000);
    io_rd(16'h0092, v);
    check({8'h0, v}, 16'h0000);
    check({11'h0, timer2_gate, speaker_enable, nmi, a20_clamp_output_b,
           cpu_reset_output}, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_io_hole();
    cfg_wr(8'h10, 8'h32);
    cfg_wr(8'h11, 8'h33);
    cfg_wr(8'h08, 8'h08);
    hole(1'b1, 28'h000031f, 1'b0);
    hole(1'b1, 28'h0000320, 1'b1);
    hole(1'b1, 28'h000032f, 1'b1);
    hole(1'b1, 28'h0000330, 1'b0);
    hole(1'b1, 28'h0001325, 1'b1);
    hole(1'b0, 28'h0000320, 1'b0);
    cfg_wr(8'h08, 8'h02);
    hole(1'b1, 28'h0000320, 1'b0);
    $display("t_io_hole done");
  endtask

  task automatic t_mem_hole();
    cfg_wr(8'h19, 8'h02);
    cfg_wr(8'h1a, 8'h01);
    cfg_wr(8'h1c, 8'h04);
    cfg_wr(8'h1d, 8'h01);
    hole(1'b0, 28'h0407fff, 1'b0);
    hole(1'b0, 28'h0408000, 1'b1);
    hole(1'b0, 28'h040ffff, 1'b1);
    hole(1'b0, 28'h0410000, 1'b0);
    hole(1'b0, 28'h0008000, 1'b0);
    hole(1'b0, 28'hc408000, 1'b0);
    cfg_wr(8'h08, 8'h00);
    hole(1'b0, 28'h0408000, 1'b0);
    $display("t_mem_hole done");
  endtask

  task automatic t_port_b();
    io_wr(16'h0061, 8'h03);
    ticks(1);
    check({14'h0, timer2_gate, speaker_enable}, 16'h0003);
    t2_req <= 1'b1;
    ticks(8);
    io_rd(16'h0061, v);
    check({8'h0, v & 8'h2f}, 16'h0023);
    ref_req <= 1'b1;
    @(negedge clk);
    ref_req <= 1'b0;
    ticks(8);
    io_rd(16'h0061, w);
    check({15'h0, w[4]}, {15'h0, !v[4]});
    t2_req <= 1'b0;
    io_wr(16'h0061, 8'h33);
    ticks(8);
    io_rd(16'h0061, v);
    check({15'h0, v[5]}, 16'h0000);
    io_wr(16'h0061, 8'h00);
    ticks(1);
    check({14'h0, timer2_gate, speaker_enable}, 16'h0000);
    $display("t_port_b done");
  endtask

  task automatic t_nmi();
    io_wr(16'h0070, 8'h05);
    check({9'h0, rtc_index}, 16'h0005);
    err_pin(1'b1);
    nmi_rd(16'h8001);
    io_wr(16'h0061, 8'h04);
    ticks(2);
    nmi_rd(16'h0000);
    io_wr(16'h0061, 8'h00);
    cfg_wr(8'h02, 8'h20);
    err_pin(1'b1);
    nmi_rd(16'h0000);
    cfg_wr(8'h02, 8'h00);
    err_pin(1'b0);
    nmi_rd(16'h4001);
    io_wr(16'h0070, 8'h85);
    ticks(2);
    nmi_rd(16'h4000);
    io_wr(16'h0061, 8'h08);
    ticks(2);
    err_pin(1'b0);
    io_rd(16'h0061, v);
    check({8'h0, v & 8'hc0}, 16'h0000);
    io_wr(16'h0061, 8'h00);
    $display("t_nmi done");
  endtask

  // Writes bit 0 and measures when, and how long, the CPU reset line rises.
  task automatic frst(input logic expect_pulse);
    int n;
    int hw;
    n = 0;
    hw = 0;
    io_wr(16'h0092, 8'h03);
    while (cpu_reset_output !== 1'b1 && n < 800) begin
      @(negedge clk);
      n++;
    end
    while (cpu_reset_output === 1'b1 && hw < 50) begin
      @(negedge clk);
      hw++;
    end
    check(16'(n), expect_pulse ? 16'd673 : 16'd800);
    check(16'(hw), expect_pulse ? 16'd13 : 16'd0);
  endtask

  task automatic t_sysctl();
    cfg_wr(8'h02, 8'h04);
    io_wr(16'h0092, 8'h02);
    ticks(2);
    check({15'h0, a20_clamp_output_b}, 16'h0001);
    kba20_req <= 1'b1;
    ticks(10);
    check({15'h0, a20_clamp_output_b}, 16'h0000);
    kba20_req <= 1'b0;
    ticks(10);
    frst(1'b1);
    io_rd(16'h0092, v);
    check({8'h0, v}, 16'h0003);
    frst(1'b0);
    io_wr(16'h0092, 8'h02);
    frst(1'b1);
    kbrst_req <= 1'b1;
    ticks(8);
    check({15'h0, cpu_reset_output}, 16'h0001);
    kbrst_req <= 1'b0;
    ticks(10);
    cfg_wr(8'h02, 8'h00);
    io_wr(16'h0092, 8'h00);
    io_rd(16'h0092, v);
    check({8'h0, v}, 16'h0000);
    cfg_wr(8'h02, 8'h04);
    io_rd(16'h0092, v);
    check({8'h0, v}, 16'h0003);
    $display("t_sysctl done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The tests need about 2600 clocks; the watchdog allows 20000.
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    {io_write, io_read, cyc_valid, cyc_is_io, par_req, chk_req} = 6'h00;
    {t2_req, kbrst_req, kba20_req, ref_req} = 4'h0;
    {io_addr, io_wdata, cyc_addr} = 52'h0;
    bad_count = 0;
    n_checks = 0;
    rst_b = 1'b0;
    ticks(4);
    rst_b <= 1'b1;
    ticks(4);
    t_regs();
    t_io_hole();
    t_mem_hole();
    t_port_b();
    t_nmi();
    t_sysctl();
    stop_test();
  end
endmodule
`default_nettype wire
